// >>> logic/sgsc_adv_store.sv
// Purpose: byte store for the advanced control window
// Assumes: one write and one read port, same clock
// Notes: read data come from a register, one cycle after the address
`default_nettype none
`include "sgsc_regs.svh"
module sgsc_adv_store #(
  parameter int DEPTH = `SGSC_ADV_WORDS,
  parameter int AW = 5
)(
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  // storage, contents undefined until written
  logic [7:0] mem [DEPTH];

  // refuse an index too narrow for the depth
  if ((1 << AW) < DEPTH)
  begin : g_chk
    $error("sgsc_adv_store: AW too small for DEPTH");
  end

  // write port
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// >>> logic/sgsc_global_ctrl.sv
// Purpose: identification, start and global control 0 registers of the switch
// Assumes: host register port and eeprom reader are synchronous to MCLK
// Notes: read answers arrive two cycles after REG_RD
`default_nettype none
`include "sgsc_regs.svh"

// Functional notes
// - chip code 7-4, revision 3-1, read-only
// - managed straps wait for start bit one
// - strap 00 starts after eeprom read attempt
// - absent eeprom keeps strap and default values
// - eeprom overrides only when both codes match
// - control bit 7 selects alternate back-off, reset 0
// - control bit 3 passes flow-control frames
// - reserved fields reset 0x4, 1, 0
// - link loss with bit 0 triggers fast age
// - any link loss ages out all addresses
// - indirect control 0x79-7A, data 0x7B-83
// - MAC address 0x70-75, user 0x76-78
// - all registers eight bits, individually addressed
module sgsc_global_ctrl
  import sgsc_pkg::*;
#(
  parameter int NUM_PORTS = 3,
  parameter logic [7:0] DEVICE_FAMILY_CODE = 8'h5A, // arbitrary value
  parameter logic [3:0] DEVICE_VARIANT_CODE = 4'h7, // arbitrary value
  parameter logic [2:0] SILICON_REVISION_CODE = 3'h1, // arbitrary value
  // fast age window, strictly under the limit
  parameter int FAST_AGE_CYCLES = (`SGSC_FAST_AGE_NS / `SGSC_CLK_NS) - 1
)(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic STRAP_MODE_SELECT_HI,
  input wire logic STRAP_MODE_SELECT_LO,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  output logic EE_REQ,
  output logic [7:0] EE_ADDR,
  input wire logic EE_DONE,
  input wire logic EE_ABSENT,
  input wire logic [7:0] EE_RDATA,
  input wire logic [NUM_PORTS-1:0] LINK_UP,
  output logic SWITCH_RUN,
  output logic BACKOFF_ALT,
  output logic PASS_FLOW_CTRL,
  output logic FAST_AGE_ACTIVE,
  output logic AGE_FLUSH
);
  localparam int CW = $clog2(FAST_AGE_CYCLES + 1);
  localparam int AW = 5;

  // refuse settings the logic cannot serve
  if (NUM_PORTS < 1 || FAST_AGE_CYCLES < 1)
  begin : g_chk
    $error("sgsc_global_ctrl: bad NUM_PORTS or FAST_AGE_CYCLES");
  end

  // address to region; shared by read and write paths
  function automatic sgsc_region_e region_of(input logic [7:0] a);
    sgsc_region_e r;
    r = SGSC_RG_NONE;
    if (a == `SGSC_ADDR_FAMILY)
      r = SGSC_RG_FAMILY;
    else if (a == `SGSC_ADDR_CHIP)
      r = SGSC_RG_CHIP;
    else if (a == `SGSC_ADDR_GC0)
      r = SGSC_RG_GC0;
    else if (a >= `SGSC_MAC_LO && a <= `SGSC_MAC_HI)
      r = SGSC_RG_ADV;
    else if (a >= `SGSC_USER_LO && a <= `SGSC_USER_HI)
      r = SGSC_RG_ADV;
    else if (a >= `SGSC_IACC_LO && a <= `SGSC_IACC_HI)
      r = SGSC_RG_ADV;
    else if (a >= `SGSC_IDATA_LO && a <= `SGSC_IDATA_HI)
      r = SGSC_RG_ADV;
    return r;
  endfunction

  logic auto_mode_ff; // straps were 00 at reset
  sgsc_boot_e boot_ff; // automatic start sequence state
  logic ee_wait_ff; // a byte request is outstanding
  logic [7:0] ee_family_ff; // eeprom image of register 0
  logic start_ff; // host start bit
  logic [7:0] gc0_ff; // global control 0
  logic [NUM_PORTS-1:0] link_prev_ff; // link state last cycle
  logic [CW-1:0] age_cnt_ff; // fast age window counter
  logic rd_pend_ff; // read accepted last cycle
  sgsc_region_e rd_region_ff; // region of that read
  logic [7:0] rd_direct_ff; // non-store read data
  logic [7:0] adv_rdata; // store read data
  logic wr_gc0;
  logic wr_adv;
  logic ee_take; // eeprom answer this cycle
  logic [NUM_PORTS-1:0] link_drop;
  logic [AW-1:0] adv_waddr;
  logic [AW-1:0] adv_raddr;

  assign wr_gc0 = REG_WR && (region_of(REG_ADDR) == SGSC_RG_GC0);
  assign wr_adv = REG_WR && (region_of(REG_ADDR) == SGSC_RG_ADV);
  assign ee_take = ee_wait_ff && EE_DONE;
  assign link_drop = link_prev_ff & ~LINK_UP;
  // store index relative to the window base; only valid in-window
  assign adv_waddr = AW'(REG_ADDR - `SGSC_MAC_LO);
  assign adv_raddr = AW'(REG_ADDR - `SGSC_MAC_LO);

  // advanced window bytes: one per address, 8 bits each
  sgsc_adv_store #(
    .DEPTH(`SGSC_ADV_WORDS),
    .AW(AW)
  ) u_adv (
    .clk(MCLK),
    .we(wr_adv),
    .waddr(adv_waddr),
    .wdata(REG_WDATA),
    .raddr(adv_raddr),
    .rdata(adv_rdata)
  );

  // strap capture; synchronous reset so the pins may be sampled here
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      auto_mode_ff <= !STRAP_MODE_SELECT_HI && !STRAP_MODE_SELECT_LO;
    end
  end

  // automatic start sequence: family byte, chip byte, control byte
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      boot_ff <= (!STRAP_MODE_SELECT_HI && !STRAP_MODE_SELECT_LO) ?
                 SGSC_RD_FAMILY : SGSC_BOOT_DONE;
    end
    else if (ee_take)
    begin
      unique case (boot_ff)
        SGSC_RD_FAMILY:
        begin
          // no answer from the eeprom: keep defaults and start
          boot_ff <= EE_ABSENT ? SGSC_BOOT_DONE : SGSC_RD_CHIP;
        end
        SGSC_RD_CHIP:
        begin
          // both codes must match before anything is loaded
          if (!EE_ABSENT && ee_family_ff == DEVICE_FAMILY_CODE &&
              EE_RDATA[`SGSC_VARIANT_MSB:`SGSC_VARIANT_LSB] == DEVICE_VARIANT_CODE)
            boot_ff <= SGSC_RD_GC0;
          else
            boot_ff <= SGSC_BOOT_DONE;
        end
        SGSC_RD_GC0:
        begin
          boot_ff <= SGSC_BOOT_DONE;
        end
        SGSC_BOOT_DONE:
        begin
          boot_ff <= SGSC_BOOT_DONE;
        end
      endcase
    end
  end

  // one-cycle byte request, then wait for the reader's answer
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      EE_REQ <= 1'b0;
      ee_wait_ff <= 1'b0;
      EE_ADDR <= `SGSC_EE_ADDR_FAMILY;
    end
    else if (boot_ff != SGSC_BOOT_DONE && !ee_wait_ff && !EE_REQ)
    begin
      EE_REQ <= 1'b1;
      ee_wait_ff <= 1'b1;
      unique case (boot_ff)
        SGSC_RD_FAMILY: EE_ADDR <= `SGSC_EE_ADDR_FAMILY;
        SGSC_RD_CHIP: EE_ADDR <= `SGSC_EE_ADDR_CHIP;
        SGSC_RD_GC0: EE_ADDR <= `SGSC_EE_ADDR_GC0;
        SGSC_BOOT_DONE: EE_ADDR <= `SGSC_EE_ADDR_FAMILY;
      endcase
    end
    else
    begin
      EE_REQ <= 1'b0;
      if (ee_take)
      begin
        ee_wait_ff <= 1'b0;
      end
    end
  end

  // keep the family byte until the chip byte is checked
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      ee_family_ff <= 8'h00;
    end
    else if (ee_take && boot_ff == SGSC_RD_FAMILY)
    begin
      ee_family_ff <= EE_RDATA;
    end
  end

  // host start bit
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      start_ff <= 1'b0;
    end
    else if (REG_WR && region_of(REG_ADDR) == SGSC_RG_CHIP)
    begin
      start_ff <= REG_WDATA[`SGSC_START_BIT];
    end
  end

  // run gate: managed straps need the start bit, 00 needs the sequence
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      SWITCH_RUN <= 1'b0;
    end
    else if (auto_mode_ff)
    begin
      SWITCH_RUN <= (boot_ff == SGSC_BOOT_DONE);
    end
    else
    begin
      SWITCH_RUN <= start_ff;
    end
  end

  // global control 0; host write wins over the eeprom load
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      gc0_ff <= `SGSC_GC0_RESET;
    end
    else if (wr_gc0)
    begin
      gc0_ff <= REG_WDATA;
    end
    else if (ee_take && boot_ff == SGSC_RD_GC0 && !EE_ABSENT)
    begin
      gc0_ff <= EE_RDATA;
    end
  end

  // control outputs follow the register one cycle later
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      BACKOFF_ALT <= 1'b0;
      PASS_FLOW_CTRL <= 1'b0;
    end
    else
    begin
      BACKOFF_ALT <= gc0_ff[`SGSC_GC0_BACKOFF_BIT];
      PASS_FLOW_CTRL <= gc0_ff[`SGSC_GC0_PASSFC_BIT];
    end
  end

  // link history for loss detection
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      link_prev_ff <= '0;
    end
    else
    begin
      link_prev_ff <= LINK_UP;
    end
  end

  // any lost link flushes the table, whatever bit 0 says
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      AGE_FLUSH <= 1'b0;
    end
    else
    begin
      AGE_FLUSH <= |link_drop;
    end
  end

  // one fast age window per loss, then back to the normal period
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      age_cnt_ff <= '0;
      FAST_AGE_ACTIVE <= 1'b0;
    end
    else if (|link_drop && gc0_ff[`SGSC_GC0_LINKAGE_BIT])
    begin
      age_cnt_ff <= CW'(FAST_AGE_CYCLES);
      FAST_AGE_ACTIVE <= 1'b1;
    end
    else if (age_cnt_ff != '0)
    begin
      age_cnt_ff <= age_cnt_ff - 1'b1;
      FAST_AGE_ACTIVE <= (age_cnt_ff != CW'(1));
    end
    else
    begin
      FAST_AGE_ACTIVE <= 1'b0;
    end
  end

  // read stage one: direct data and region capture
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      rd_pend_ff <= 1'b0;
      rd_region_ff <= SGSC_RG_NONE;
      rd_direct_ff <= 8'h00;
    end
    else
    begin
      rd_pend_ff <= REG_RD;
      rd_region_ff <= region_of(REG_ADDR);
      unique case (region_of(REG_ADDR))
        SGSC_RG_FAMILY: rd_direct_ff <= DEVICE_FAMILY_CODE;
        SGSC_RG_CHIP: rd_direct_ff <= {DEVICE_VARIANT_CODE, SILICON_REVISION_CODE,
                                       auto_mode_ff ? SWITCH_RUN : start_ff};
        SGSC_RG_GC0: rd_direct_ff <= gc0_ff;
        SGSC_RG_ADV: rd_direct_ff <= 8'h00;
        SGSC_RG_NONE: rd_direct_ff <= 8'h00; // unmapped reads zero
      endcase
    end
  end

  // read stage two: answer with a one-cycle valid
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= rd_pend_ff;
      if (rd_pend_ff)
      begin
        REG_RDATA <= (rd_region_ff == SGSC_RG_ADV) ? adv_rdata : rd_direct_ff;
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/sgsc_pkg.sv
// Purpose: types shared by the start and control block
// Assumes: nothing beyond the register header
// Notes: constants live in sgsc_regs.svh
`default_nettype none
package sgsc_pkg;
  // automatic start sequence, gray along the eeprom path
  typedef enum logic [1:0] {
    SGSC_RD_FAMILY = 2'b00,
    SGSC_RD_CHIP = 2'b01,
    SGSC_RD_GC0 = 2'b11,
    SGSC_BOOT_DONE = 2'b10
  } sgsc_boot_e;
  // register address regions
  typedef enum logic [2:0] {
    SGSC_RG_NONE,
    SGSC_RG_FAMILY,
    SGSC_RG_CHIP,
    SGSC_RG_GC0,
    SGSC_RG_ADV
  } sgsc_region_e;
endpackage
`default_nettype wire

// >>> logic/sgsc_regs.svh
// Purpose: offsets, field positions, reset values and timing figures
// Assumes: 8-bit registers, one byte per address
// Notes: definitions only
`ifndef SGSC_REGS_SVH
`define SGSC_REGS_SVH
// global register offsets
`define SGSC_ADDR_FAMILY 8'h00
`define SGSC_ADDR_CHIP 8'h01
`define SGSC_ADDR_GC0 8'h02
// advanced control space windows
`define SGSC_MAC_LO 8'h70
`define SGSC_MAC_HI 8'h75
`define SGSC_USER_LO 8'h76
`define SGSC_USER_HI 8'h78
`define SGSC_IACC_LO 8'h79
`define SGSC_IACC_HI 8'h7A
`define SGSC_IDATA_LO 8'h7B
`define SGSC_IDATA_HI 8'h83
// words held in the advanced store (0x70..0x83)
`define SGSC_ADV_WORDS 20
// chip code register fields
`define SGSC_VARIANT_MSB 7
`define SGSC_VARIANT_LSB 4
`define SGSC_REV_MSB 3
`define SGSC_REV_LSB 1
`define SGSC_START_BIT 0
// global control 0 fields
`define SGSC_GC0_BACKOFF_BIT 7
`define SGSC_GC0_PASSFC_BIT 3
`define SGSC_GC0_LINKAGE_BIT 0
// reserved 6-4 = 0x4, reserved 2 = 1, reserved 1 = 0
`define SGSC_GC0_RESET 8'h44
// eeprom image byte addresses
`define SGSC_EE_ADDR_FAMILY 8'h00
`define SGSC_EE_ADDR_CHIP 8'h01
`define SGSC_EE_ADDR_GC0 8'h02
// timing
`define SGSC_FAST_AGE_NS 800000
`define SGSC_CLK_NS 8
`define SGSC_NORMAL_AGE_S 200
`endif

// >>> sim/sgsc_chk_sva.sv
// Purpose: port-level checks of the start and control block
// Assumes: one clock, straps held stable while out of reset
// Notes: bound to sgsc_global_ctrl below
`default_nettype none
module sgsc_chk #(
  parameter int NUM_PORTS = 3,
  parameter logic [7:0] DEVICE_FAMILY_CODE = 8'h00,
  parameter logic [3:0] DEVICE_VARIANT_CODE = 4'h0,
  parameter logic [2:0] SILICON_REVISION_CODE = 3'h0,
  parameter int FAST_AGE_CYCLES = 1
)(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic STRAP_MODE_SELECT_HI,
  input wire logic STRAP_MODE_SELECT_LO,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic [NUM_PORTS-1:0] LINK_UP,
  input wire logic SWITCH_RUN,
  input wire logic BACKOFF_ALT,
  input wire logic PASS_FLOW_CTRL,
  input wire logic FAST_AGE_ACTIVE,
  input wire logic AGE_FLUSH
);
  logic [NUM_PORTS-1:0] link_q; // link levels one cycle back
  int fa_len; // cycles spent in the current fast age window
  wire drop = |(link_q & ~LINK_UP); // some port lost its link
  wire managed = STRAP_MODE_SELECT_HI | STRAP_MODE_SELECT_LO;
  wire unmapped = (REG_ADDR > 8'h02 && REG_ADDR < 8'h70) || REG_ADDR > 8'h83;
  // link history for the drop detector
  always_ff @(posedge MCLK)
    link_q <= LINK_UP;
  // window length, restarted by a flush so retriggers stay legal
  always_ff @(posedge MCLK)
    if (RESET || !FAST_AGE_ACTIVE)
      fa_len <= 0;
    else if (AGE_FLUSH)
      fa_len <= 1;
    else
      fa_len <= fa_len + 1;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  property p_rd_lat; REG_RD |-> ##2 REG_RVALID; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rv_cause; REG_RVALID |-> $past(REG_RD, 2); endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("stray answer");
  property p_family; REG_RD && REG_ADDR == 8'h00 |-> ##2 REG_RDATA == DEVICE_FAMILY_CODE;
  endproperty
  a_family: assert property (p_family) else $error("family code");
  property p_chip; REG_RD && REG_ADDR == 8'h01 |->
    ##2 REG_RDATA[7:1] == {DEVICE_VARIANT_CODE, SILICON_REVISION_CODE}; endproperty
  a_chip: assert property (p_chip) else $error("chip code");
  property p_unmapped; REG_RD && unmapped |-> ##2 REG_RDATA == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_backoff; REG_WR && REG_ADDR == 8'h02 ##1 !REG_WR |->
    ##1 BACKOFF_ALT == $past(REG_WDATA[7], 2); endproperty
  a_backoff: assert property (p_backoff) else $error("back-off bit");
  property p_passfc; REG_WR && REG_ADDR == 8'h02 ##1 !REG_WR |->
    ##1 PASS_FLOW_CTRL == $past(REG_WDATA[3], 2); endproperty
  a_passfc: assert property (p_passfc) else $error("pass bit");
  property p_run; managed && REG_WR && REG_ADDR == 8'h01 ##1 !REG_WR |->
    ##1 SWITCH_RUN == $past(REG_WDATA[0], 2); endproperty
  a_run: assert property (p_run) else $error("start bit");
  property p_run_cause; managed && $rose(SWITCH_RUN) |->
    $past(REG_WR, 2) && $past(REG_ADDR, 2) == 8'h01; endproperty
  a_run_cause: assert property (p_run_cause) else $error("run w/o start");
  property p_flush; drop |=> AGE_FLUSH; endproperty
  a_flush: assert property (p_flush) else $error("no flush");
  property p_flush_cause; AGE_FLUSH |-> $past(drop); endproperty
  a_flush_cause: assert property (p_flush_cause) else $error("stray flush");
  property p_fa_start; $rose(FAST_AGE_ACTIVE) |-> AGE_FLUSH; endproperty
  a_fa_start: assert property (p_fa_start) else $error("fast age cause");
  property p_fa_len; $fell(FAST_AGE_ACTIVE) && !$past(RESET) |-> fa_len == FAST_AGE_CYCLES;
  endproperty
  a_fa_len: assert property (p_fa_len) else $error("fast age length");
  c_managed: cover property (managed && $rose(SWITCH_RUN));
  c_auto: cover property (!managed && $rose(SWITCH_RUN));
  c_fast: cover property ($fell(FAST_AGE_ACTIVE));
endmodule
bind sgsc_global_ctrl sgsc_chk #(.NUM_PORTS(NUM_PORTS),
  .DEVICE_FAMILY_CODE(DEVICE_FAMILY_CODE), .DEVICE_VARIANT_CODE(DEVICE_VARIANT_CODE),
  .SILICON_REVISION_CODE(SILICON_REVISION_CODE), .FAST_AGE_CYCLES(FAST_AGE_CYCLES)
) sgsc_chk_inst (.MCLK(MCLK), .RESET(RESET), .STRAP_MODE_SELECT_HI(STRAP_MODE_SELECT_HI),
  .STRAP_MODE_SELECT_LO(STRAP_MODE_SELECT_LO), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .LINK_UP(LINK_UP), .SWITCH_RUN(SWITCH_RUN), .BACKOFF_ALT(BACKOFF_ALT),
  .PASS_FLOW_CTRL(PASS_FLOW_CTRL), .FAST_AGE_ACTIVE(FAST_AGE_ACTIVE), .AGE_FLUSH(AGE_FLUSH));
`default_nettype wire

// >>> sim/switch_global_start_control_test.sv
// Purpose: directed register test of the start and control block
// Assumes: fast age window shortened to 20 cycles
// Notes: the bench answers eeprom reads itself
`default_nettype none
module switch_global_start_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FA = 20; // short window keeps the run brief
  logic mclk, reset, s_hi, s_lo, reg_wr, reg_rd, ee_done, ee_absent; // driven
  logic rvalid, ee_req, run, bko, pfc, fast, flush; // observed
  logic [7:0] addr, wdata, rdata, ee_addr, ee_data;
  logic [2:0] link; // per-port link levels
  int fail_count, tests_run, ee_cnt, fa_cnt, fl_cnt, i;
  logic [7:0] adv [8] = '{8'h70, 8'h75, 8'h76, 8'h78, 8'h79, 8'h7A, 8'h7B, 8'h83};
  // codes below are arbitrary
  sgsc_global_ctrl #(.DEVICE_FAMILY_CODE(8'hC3), .DEVICE_VARIANT_CODE(4'h9),
    .SILICON_REVISION_CODE(3'h5), .FAST_AGE_CYCLES(FA)) sgsc_global_ctrl_inst (
    .MCLK(mclk), .RESET(reset), .STRAP_MODE_SELECT_HI(s_hi), .STRAP_MODE_SELECT_LO(s_lo),
    .REG_ADDR(addr), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .EE_REQ(ee_req), .EE_ADDR(ee_addr),
    .EE_DONE(ee_done), .EE_ABSENT(ee_absent), .EE_RDATA(ee_data), .LINK_UP(link),
    .SWITCH_RUN(run), .BACKOFF_ALT(bko), .PASS_FLOW_CTRL(pfc),
    .FAST_AGE_ACTIVE(fast), .AGE_FLUSH(flush));
  // 8 ns clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // event counters, cleared by reset
  always @(posedge mclk)
  begin
    ee_cnt <= reset ? 0 : ee_cnt + int'(ee_req);
    fa_cnt <= reset ? 0 : fa_cnt + int'(fast);
    fl_cnt <= reset ? 0 : fl_cnt + int'(flush);
  end
  // hang guard, far beyond the expected run
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    summarize();
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one write, strobe dropped with a spare edge after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // one read, answer awaited under a bound
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int n;
    n = 0;
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    do begin @(posedge mclk); #1; n++; end while (rvalid !== 1'b1 && n < 4);
    chk({7'h00, rvalid}, 8'h01, "answer");
    chk(rdata, e, "read data");
    @(posedge mclk);
  endtask
  // straps held through two reset edges; returns at the release edge
  task automatic rst(input logic [1:0] m);
    {s_hi, s_lo} <= m;
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
  endtask
  // answer one eeprom request; data line scrambled afterwards
  task automatic ee(input logic ab, input logic [7:0] d, input logic [7:0] a);
    int n;
    n = 0;
    do begin @(posedge mclk); #1; n++; end while (ee_req !== 1'b1 && n < 10);
    chk({ee_req, ee_addr[6:0]}, {1'b1, a[6:0]}, "eeprom request");
    @(posedge mclk);
    ee_done <= 1'b1;
    ee_absent <= ab;
    ee_data <= d;
    @(posedge mclk);
    ee_done <= 1'b0;
    ee_data <= ~d;
  endtask
  // automatic start with n eeprom bytes, expecting control 0 = g
  task automatic boot(input logic ab, input logic [7:0] b0, b1, b2, input int n,
    input logic [7:0] g);
    rst(2'b00);
    ee(ab, b0, 8'h00);
    if (n > 1)
      chk({7'h00, run}, 8'h00, "early run");
    if (n > 1)
      ee(1'b0, b1, 8'h01);
    if (n > 2)
      ee(1'b0, b2, 8'h02);
    repeat (4) @(posedge mclk);
    chk(8'(ee_cnt), 8'(n), "request count");
    chk({7'h00, run}, 8'h01, "auto run");
    rd(8'h02, g);
    chk({6'h00, bko, pfc}, {6'h00, g[7], g[3]}, "loaded bits");
    rd(8'h01, 8'h9B);
  endtask
  // drop links, restore, then compare flush count and fast age cycle count
  task automatic drop(input logic [2:0] l, input int nfl, input int nfa);
    link <= l;
    repeat (FA + 5) @(posedge mclk);
    link <= 3'b111;
    repeat (2) @(posedge mclk);
    chk(8'(fl_cnt), 8'(nfl), "flush count");
    chk(8'(fa_cnt), 8'(nfa), "fast age cycles");
  endtask
  initial
  begin
    {reg_wr, reg_rd, ee_done, ee_absent} = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
    ee_data = 8'h00;
    link = 3'b111;
    fail_count = 0;
    tests_run = 0;
    for (i = 1; i < 4; i++)
    begin
      rst(2'(i));
      repeat (5) @(posedge mclk);
      chk({7'h00, run}, 8'h00, "held");
      rd(8'h01, 8'h9A);
      wr(8'h01, 8'hFF);
      rd(8'h01, 8'h9B);
      chk({7'h00, run}, 8'h01, "started");
      wr(8'h01, 8'h00);
      rd(8'h01, 8'h9A);
      chk({7'h00, run}, 8'h00, "stopped");
    end
    $display("test managed start done");
    rd(8'h02, 8'h44);
    chk({6'h00, bko, pfc}, 8'h00, "control reset");
    wr(8'h02, 8'h89);
    rd(8'h02, 8'h89);
    chk({6'h00, bko, pfc}, 8'h03, "control set");
    drop(3'b101, 1, FA);
    wr(8'h02, 8'hC8);
    drop(3'b010, 2, FA);
    $display("test control done");
    wr(8'h00, 8'h00);
    rd(8'h00, 8'hC3);
    foreach (adv[k])
      wr(adv[k], ~adv[k]);
    foreach (adv[k])
      rd(adv[k], ~adv[k]);
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'h00);
    wr(8'h84, 8'hFF);
    rd(8'h84, 8'h00);
    rd(8'h6F, 8'h00);
    $display("test map done");
    boot(1'b1, 8'h00, 8'h00, 8'h00, 1, 8'h44);
    boot(1'b0, 8'hC2, 8'h9E, 8'h00, 2, 8'h44);
    boot(1'b0, 8'hC3, 8'h6B, 8'h00, 2, 8'h44);
    boot(1'b0, 8'hC3, 8'h9E, 8'h8D, 3, 8'h8D);
    $display("test auto start done");
    summarize();
  end
endmodule
`default_nettype wire
